// ---- common/bsc_pkg.sv ----
// constants, register map and carrier types of the brake sequence control block
package bsc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned TICK_NS = 10_000_000;
   localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned FAULT_TIME_MS = 2000;
   localparam logic [15:0] FAULT_TICKS = 16'(FAULT_TIME_MS * 1_000_000 / TICK_NS);

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FREQ = 8'h04;
   localparam logic [7:0] ADDR_CURR = 8'h08;
   localparam logic [7:0] ADDR_TIME1 = 8'h0c;
   localparam logic [7:0] ADDR_TIME2 = 8'h10;
   localparam logic [7:0] ADDR_TIME3 = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_MASK = 8'h1c;
   localparam logic [7:0] ADDR_STATE = 8'h20;

   localparam int unsigned CTRL_DIR_BIT = 0;
   localparam int unsigned CTRL_ZSEL_BIT = 1;

   localparam logic [15:0] DISABLED = 16'h270f;
   // frequencies in 0.1 Hz, currents in %, times in 10 ms ticks
   localparam logic [15:0] RST_RELEASE_FREQ = 16'h001e;
   localparam logic [15:0] RST_ENGAGE_FREQ = 16'h003c;
   localparam logic [15:0] RST_RELEASE_CURR = 16'h0082;
   localparam logic [15:0] RST_REVERSE_CURR = DISABLED;
   localparam logic [15:0] RST_DETECT_TIME = 16'h001e;
   localparam logic [15:0] RST_START_DELAY = 16'h001e;
   localparam logic [15:0] RST_STOP_DELAY = 16'h001e;
   localparam logic [15:0] RST_DECEL_HOLD = 16'h012c;
   localparam logic [15:0] RST_START_DELAY2 = DISABLED;
   localparam logic [15:0] RST_POS_RANGE = DISABLED;
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [15:0] MAX_FREQ = 16'h012c;
   localparam logic [15:0] MAX_CURR = 16'h0190;
   localparam logic [15:0] MAX_DETECT = 16'h00c8;
   localparam logic [15:0] MAX_DELAY = 16'h01f4;
   localparam logic [15:0] MAX_HOLD = 16'h0bb8;
   localparam logic [15:0] MAX_RANGE = 16'h03e8;

   localparam int unsigned EV_FAULT = 0;
   localparam int unsigned EV_RELEASE = 1;
   localparam int unsigned EV_ENGAGE = 2;
   localparam int unsigned EV_SHUTOFF = 3;
   localparam int unsigned NUM_EV = 4;

   typedef enum logic [2:0] {
      ST_IDLE, ST_MAGNETIZE, ST_START_DELAY, ST_RUN, ST_STOP_DELAY
   } bsc_state_type;

   typedef struct packed {
      logic [15:0] release_freq;
      logic [15:0] engage_freq;
      logic [15:0] release_curr;
      logic [15:0] reverse_curr;
      logic [15:0] detect_time;
      logic [15:0] start_delay;
      logic [15:0] stop_delay;
      logic [15:0] decel_hold;
      logic [15:0] start_delay2;
      logic [15:0] pos_range;
   } bsc_cfg_type;

   typedef struct packed {
      logic start_cmd;
      logic premagnetize_input;
      logic brake_release_done;
      logic reverse_cmd;
      logic shutoff_req;
      logic position_near;
   } bsc_pins_type;
endpackage

// ---- core/bsc_brake_seq.sv ----
// brake sequence controller with apb register file and distance sense setting
//
// Behaviour
// - direction setting 1 inverts distance data sense; 0 keeps it.
// - current detection time 0..2 s, default 0.3 s.
// - release frequency 0..30 Hz, default 3 Hz, held during start.
// - start brake delay 0..5 s, default 0.3 s, before acceleration.
// - request drops at engage frequency 0..30 Hz, default 6 Hz.
// - after request drops, stop delay 0..5 s then output off.
// - decelerating below engage frequency, hold time 0..30 s, then drop.
// - second start delay 0..2 s, 9999 disables it.
// - drop request within position range of stop, 9999 defers to input.
// - selection 1 also drops on zero frequency command in position feed.
// - reverse rotation uses separate threshold unless it holds 9999.
// - request rises once flux ready after premagnetize or start; drops at shutoff.
// - fault when release done input keeps its state after request changes.
// - hold timer clears on expiry, output shutoff or next feed start.
`timescale 1ns/10ps
module bsc_brake_seq
   import bsc_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic start_cmd,
   input wire logic premagnetize_input,
   input wire logic brake_release_done,
   input wire logic reverse_cmd,
   input wire logic shutoff_req,
   input wire logic position_near,
   input wire logic flux_ready,
   input wire logic decelerating,
   input wire logic position_feed,
   input wire logic [15:0] out_freq,
   input wire logic [15:0] freq_cmd,
   input wire logic [15:0] motor_current,
   input wire logic [15:0] dist_to_stop,
   input wire logic [31:0] dist_data,
   output logic [31:0] dist_data_adj,
   output logic brake_release_request,
   output logic output_on,
   output logic accel_permit,
   output logic [15:0] hold_freq,
   output logic irq
);
   bsc_cfg_type cfg_r;
   logic [1:0] ctrl_r;
   logic [NUM_EV-1:0] status_r;
   logic [NUM_EV-1:0] mask_r;
   logic [NUM_EV-1:0] ev;
   bsc_pins_type pins_raw;
   bsc_pins_type sync1_r;
   bsc_pins_type sync2_r;
   bsc_pins_type prev_r;
   bsc_state_type state_r;
   logic [31:0] tick_cnt_r;
   logic tick;
   logic [15:0] st_cnt_r;
   logic [15:0] cur_cnt_r;
   logic cur_ok_r;
   logic [15:0] hold_cnt_r;
   logic hold_run_r;
   logic [15:0] flt_cnt_r;
   logic flt_arm_r;
   logic req_prev_r;
   logic [15:0] thresh;
   logic [15:0] start_total;
   logic feed_start;
   logic drop_cond;
   logic hold_done;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [31:0] rdata;

   // pins come from outside the clock domain
   assign pins_raw = '{start_cmd: start_cmd, premagnetize_input: premagnetize_input,
                      brake_release_done: brake_release_done, reverse_cmd: reverse_cmd,
                      shutoff_req: shutoff_req, position_near: position_near};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
      end else begin
         sync1_r <= pins_raw;
         sync2_r <= sync1_r;
         prev_r <= sync2_r;
      end
   end

   // apb slave: no wait states, unmapped offsets answer with pslverr
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_FREQ) || (paddr == ADDR_CURR) ||
                    (paddr == ADDR_TIME1) || (paddr == ADDR_TIME2) ||
                    (paddr == ADDR_TIME3) || (paddr == ADDR_STATUS) ||
                    (paddr == ADDR_MASK) || (paddr == ADDR_STATE);
   assign pslverr = psel && penable && !addr_ok;

   // settings are clamped to their ranges at write time
   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim,
                                         input logic allow_off);
      if (allow_off && v == DISABLED) begin
         return v;
      end
      return (v > lim) ? lim : v;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= RST_CTRL;
         mask_r <= '0;
         cfg_r.release_freq <= RST_RELEASE_FREQ;
         cfg_r.engage_freq <= RST_ENGAGE_FREQ;
         cfg_r.release_curr <= RST_RELEASE_CURR;
         cfg_r.reverse_curr <= RST_REVERSE_CURR;
         cfg_r.detect_time <= RST_DETECT_TIME;
         cfg_r.start_delay <= RST_START_DELAY;
         cfg_r.stop_delay <= RST_STOP_DELAY;
         cfg_r.decel_hold <= RST_DECEL_HOLD;
         cfg_r.start_delay2 <= RST_START_DELAY2;
         cfg_r.pos_range <= RST_POS_RANGE;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_CTRL: ctrl_r <= pwdata[1:0];
            ADDR_FREQ: begin
               cfg_r.release_freq <= clamp(pwdata[15:0], MAX_FREQ, 1'b0);
               cfg_r.engage_freq <= clamp(pwdata[31:16], MAX_FREQ, 1'b0);
            end
            ADDR_CURR: begin
               cfg_r.release_curr <= clamp(pwdata[15:0], MAX_CURR, 1'b0);
               cfg_r.reverse_curr <= clamp(pwdata[31:16], MAX_CURR, 1'b1);
            end
            ADDR_TIME1: begin
               cfg_r.detect_time <= clamp(pwdata[15:0], MAX_DETECT, 1'b0);
               cfg_r.start_delay <= clamp(pwdata[31:16], MAX_DELAY, 1'b0);
            end
            ADDR_TIME2: begin
               cfg_r.stop_delay <= clamp(pwdata[15:0], MAX_DELAY, 1'b0);
               cfg_r.decel_hold <= clamp(pwdata[31:16], MAX_HOLD, 1'b0);
            end
            ADDR_TIME3: begin
               cfg_r.start_delay2 <= clamp(pwdata[15:0], MAX_DETECT, 1'b1);
               cfg_r.pos_range <= clamp(pwdata[31:16], MAX_RANGE, 1'b1);
            end
            ADDR_MASK: mask_r <= pwdata[NUM_EV-1:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      rdata = 32'h0;
      unique case (paddr)
         ADDR_CTRL: rdata = {30'h0, ctrl_r};
         ADDR_FREQ: rdata = {cfg_r.engage_freq, cfg_r.release_freq};
         ADDR_CURR: rdata = {cfg_r.reverse_curr, cfg_r.release_curr};
         ADDR_TIME1: rdata = {cfg_r.start_delay, cfg_r.detect_time};
         ADDR_TIME2: rdata = {cfg_r.decel_hold, cfg_r.stop_delay};
         ADDR_TIME3: rdata = {cfg_r.pos_range, cfg_r.start_delay2};
         ADDR_STATUS: rdata = {{(32 - NUM_EV){1'b0}}, status_r};
         ADDR_MASK: rdata = {{(32 - NUM_EV){1'b0}}, mask_r};
         ADDR_STATE: rdata = {25'h0, cur_ok_r, output_on, brake_release_request,
                              1'b0, state_r};
         default: rdata = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rdata;
      end
   end

   // status clears on the read's access edge; a new event in that edge wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= '0;
      end else if (rd_en && paddr == ADDR_STATUS) begin
         status_r <= ev;
      end else begin
         status_r <= status_r | ev;
      end
   end

   assign irq = |(status_r & mask_r);

   // one common time base for every brake time
   assign tick = (tick_cnt_r == TICK_CYC - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_r <= 32'h0;
      end else if (tick) begin
         tick_cnt_r <= 32'h0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dist_data_adj <= 32'h0;
      end else if (ctrl_r[CTRL_DIR_BIT]) begin
         dist_data_adj <= 32'h0 - dist_data;
      end else begin
         dist_data_adj <= dist_data;
      end
   end

   assign thresh = (sync2_r.reverse_cmd && cfg_r.reverse_curr != DISABLED) ?
                   cfg_r.reverse_curr : cfg_r.release_curr;
   assign start_total = cfg_r.start_delay +
                        ((cfg_r.start_delay2 == DISABLED) ? 16'h0 : cfg_r.start_delay2);
   assign feed_start = sync2_r.start_cmd && !prev_r.start_cmd;

   // current must stay above threshold for the detection time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_cnt_r <= 16'h0;
         cur_ok_r <= 1'b0;
      end else if (!brake_release_request || motor_current < thresh) begin
         cur_cnt_r <= 16'h0;
         cur_ok_r <= 1'b0;
      end else if (cur_cnt_r >= cfg_r.detect_time) begin
         cur_ok_r <= 1'b1;
      end else if (tick) begin
         cur_cnt_r <= cur_cnt_r + 16'h1;
      end
   end

   // deceleration hold timer
   assign hold_done = hold_run_r && (hold_cnt_r >= cfg_r.decel_hold);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt_r <= 16'h0;
         hold_run_r <= 1'b0;
      end else if (hold_done || !output_on || feed_start) begin
         hold_cnt_r <= 16'h0;
         hold_run_r <= 1'b0;
      end else if (state_r == ST_RUN && decelerating && out_freq <= cfg_r.engage_freq) begin
         hold_run_r <= 1'b1;
         if (tick && hold_run_r) begin
            hold_cnt_r <= hold_cnt_r + 16'h1;
         end
      end
   end

   always_comb begin
      drop_cond = hold_done;
      if (position_feed) begin
         if (cfg_r.pos_range == DISABLED) begin
            drop_cond = drop_cond || sync2_r.position_near;
         end else begin
            drop_cond = drop_cond || (decelerating && dist_to_stop <= cfg_r.pos_range);
         end
         if (ctrl_r[CTRL_ZSEL_BIT] && freq_cmd == 16'h0) begin
            drop_cond = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         st_cnt_r <= 16'h0;
      end else if (sync2_r.shutoff_req && state_r != ST_IDLE) begin
         state_r <= ST_IDLE;
         st_cnt_r <= 16'h0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (sync2_r.premagnetize_input || sync2_r.start_cmd) begin
                  state_r <= ST_MAGNETIZE;
               end
            end
            ST_MAGNETIZE: begin
               if (!sync2_r.premagnetize_input && !sync2_r.start_cmd) begin
                  state_r <= ST_IDLE;
               end else if (flux_ready) begin
                  state_r <= ST_START_DELAY;
                  st_cnt_r <= 16'h0;
               end
            end
            ST_START_DELAY: begin
               // premagnetize alone waits here until start arrives
               if (!sync2_r.start_cmd && !sync2_r.premagnetize_input) begin
                  state_r <= ST_STOP_DELAY;
                  st_cnt_r <= 16'h0;
               end else if (st_cnt_r >= start_total && cur_ok_r && sync2_r.start_cmd) begin
                  state_r <= ST_RUN;
               end else if (tick && st_cnt_r < start_total) begin
                  st_cnt_r <= st_cnt_r + 16'h1;
               end
            end
            ST_RUN: begin
               if (drop_cond) begin
                  state_r <= ST_STOP_DELAY;
                  st_cnt_r <= 16'h0;
               end
            end
            ST_STOP_DELAY: begin
               if (feed_start) begin
                  state_r <= ST_MAGNETIZE;
               end else if (st_cnt_r >= cfg_r.stop_delay) begin
                  state_r <= ST_IDLE;
               end else if (tick) begin
                  st_cnt_r <= st_cnt_r + 16'h1;
               end
            end
         endcase
      end
   end

   assign brake_release_request = (state_r == ST_START_DELAY) || (state_r == ST_RUN);
   assign output_on = (state_r != ST_IDLE);
   assign accel_permit = (state_r == ST_RUN);
   assign hold_freq = cfg_r.release_freq;

   // brake answer watchdog, armed on every change of the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_prev_r <= 1'b0;
         flt_arm_r <= 1'b0;
         flt_cnt_r <= 16'h0;
      end else begin
         req_prev_r <= brake_release_request;
         if (req_prev_r != brake_release_request) begin
            flt_arm_r <= 1'b1;
            flt_cnt_r <= 16'h0;
         end else if (flt_arm_r && sync2_r.brake_release_done == brake_release_request) begin
            flt_arm_r <= 1'b0;
         end else if (flt_arm_r && flt_cnt_r >= FAULT_TICKS) begin
            flt_arm_r <= 1'b0;
         end else if (flt_arm_r && tick) begin
            flt_cnt_r <= flt_cnt_r + 16'h1;
         end
      end
   end

   assign ev[EV_FAULT] = flt_arm_r && flt_cnt_r >= FAULT_TICKS &&
                         sync2_r.brake_release_done != brake_release_request;
   assign ev[EV_RELEASE] = brake_release_request && !req_prev_r;
   assign ev[EV_ENGAGE] = !brake_release_request && req_prev_r;
   assign ev[EV_SHUTOFF] = sync2_r.shutoff_req && !prev_r.shutoff_req;
endmodule // bsc_brake_seq

// ---- test/bsc_brake_seq_checker.sv ----
// port assertions for the brake sequence block
`timescale 1ns/10ps
module bsc_brake_seq_checker
   import bsc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic shutoff_req,
   input wire logic brake_release_request,
   input wire logic output_on,
   input wire logic accel_permit,
   input wire logic [15:0] hold_freq,
   input wire logic irq,
   input wire logic [31:0] dist_data,
   input wire logic [31:0] dist_data_adj
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // shutoff is held past the two-stage input sync
   sequence s_shutoff_held;
      shutoff_req [*4];
   endsequence
   sequence s_idle;
      !output_on && !brake_release_request;
   endsequence
   sequence s_freq_write;
      psel && penable && pwrite && paddr == ADDR_FREQ && pwdata[15:0] <= MAX_FREQ;
   endsequence
   AST_SHUTOFF_IDLE: assert property (s_shutoff_held |-> ##[0:3] s_idle)
      else $error("output still on after shutoff");
   AST_RISE_FROM_ON: assert property ($rose(brake_release_request) |-> $past(output_on))
      else $error("request rose while output off");
   AST_REQ_NEEDS_ON: assert property (brake_release_request |-> output_on)
      else $error("request high with output off");
   AST_PERMIT_NEEDS_REQ: assert property (accel_permit |-> brake_release_request)
      else $error("acceleration allowed with brake held");
   AST_HOLD_FREQ: assert property (s_freq_write |=>
      {16'h0, hold_freq} == ($past(pwdata) & 32'h0000ffff))
      else $error("hold frequency not taken from write");
   AST_IRQ_STICKY: assert property (irq && !(psel &&
      (paddr == ADDR_STATUS || paddr == ADDR_MASK)) |=> irq)
      else $error("interrupt dropped without status read");
   AST_SLVERR: assert property (psel && penable |->
      pslverr == (paddr > ADDR_STATE || paddr[1:0] != 2'h0))
      else $error("slave error wrong for address");
   AST_DIST_SENSE: assert property ($past(presetn) |->
      dist_data_adj == $past(dist_data) || dist_data_adj == -$past(dist_data))
      else $error("distance data not passed or negated");
endmodule // bsc_brake_seq_checker

bind bsc_brake_seq bsc_brake_seq_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .shutoff_req(shutoff_req), .brake_release_request(brake_release_request),
   .output_on(output_on), .accel_permit(accel_permit), .hold_freq(hold_freq), .irq(irq),
   .dist_data(dist_data), .dist_data_adj(dist_data_adj));

// ---- test/bsc_brake_model.sv ----
// behavioural mechanical brake answering the release request
`timescale 1ns/10ps
module bsc_brake_model #(
   parameter int unsigned LAG = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic brake_release_request,
   input wire logic stuck,
   output logic brake_release_done
);
   int unsigned cnt_r;
   // a stuck brake never reports, which the fault timer must catch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 0;
         brake_release_done <= 1'b0;
      end else if (stuck || brake_release_done == brake_release_request) begin
         cnt_r <= 0;
      end else if (cnt_r >= LAG) begin
         brake_release_done <= brake_release_request;
         cnt_r <= 0;
      end else begin
         cnt_r <= cnt_r + 1;
      end
   end
endmodule // bsc_brake_model

// ---- test/bsc_brake_seq_tb.sv ----
// self-checking bench for the brake sequence block
`timescale 1ns/10ps
module bsc_brake_seq_tb;
   import bsc_pkg::*;
   localparam int unsigned TK = 4;
   typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} bsc_row_type;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, dist_data = '0, dist_data_adj, rd;
   logic start_cmd = 0, premagnetize_input = 0, brake_release_done, reverse_cmd = 0;
   logic shutoff_req = 0, position_near = 0, flux_ready = 0, decelerating = 0;
   logic position_feed = 0, brake_release_request, output_on, accel_permit, irq, stuck = 0;
   logic [15:0] out_freq = '0, freq_cmd = 16'h0064, motor_current = '0;
   logic [15:0] dist_to_stop = 16'h0100, hold_freq;
   int bad_count = 0, n_tests = 0, cyc;
   bsc_row_type rows [20] = '{
      '{ADDR_CTRL, 1'b0, 32'h0, 32'h0},
      '{ADDR_FREQ, 1'b0, 32'h0, {RST_ENGAGE_FREQ, RST_RELEASE_FREQ}},
      '{ADDR_CURR, 1'b0, 32'h0, {RST_REVERSE_CURR, RST_RELEASE_CURR}},
      '{ADDR_TIME1, 1'b0, 32'h0, {RST_START_DELAY, RST_DETECT_TIME}},
      '{ADDR_TIME2, 1'b0, 32'h0, {RST_DECEL_HOLD, RST_STOP_DELAY}},
      '{ADDR_TIME3, 1'b0, 32'h0, {RST_POS_RANGE, RST_START_DELAY2}},
      '{ADDR_STATUS, 1'b0, 32'h0, 32'h0},
      '{ADDR_MASK, 1'b0, 32'h0, 32'h0},
      '{ADDR_FREQ, 1'b1, 32'hffffffff, {MAX_FREQ, MAX_FREQ}},
      '{ADDR_CURR, 1'b1, 32'hffffffff, {MAX_CURR, MAX_CURR}},
      '{ADDR_TIME1, 1'b1, 32'hffffffff, {MAX_DELAY, MAX_DETECT}},
      '{ADDR_TIME2, 1'b1, 32'hffffffff, {MAX_HOLD, MAX_DELAY}},
      '{ADDR_TIME3, 1'b1, 32'hffffffff, {MAX_RANGE, MAX_DETECT}},
      '{ADDR_FREQ, 1'b1, 32'h003c001e, 32'h003c001e},
      '{ADDR_CURR, 1'b1, {DISABLED, 16'h0032}, {DISABLED, 16'h0032}},
      '{ADDR_TIME1, 1'b1, 32'h00030002, 32'h00030002},
      '{ADDR_TIME2, 1'b1, 32'h00030002, 32'h00030002},
      '{ADDR_TIME3, 1'b1, {DISABLED, DISABLED}, {DISABLED, DISABLED}},
      '{ADDR_MASK, 1'b1, 32'h1, 32'h1},
      '{8'h24, 1'b1, 32'h12345678, 32'h0}
   };

   bsc_brake_seq #(.TICK_CYC(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .start_cmd(start_cmd),
      .premagnetize_input(premagnetize_input), .brake_release_done(brake_release_done),
      .reverse_cmd(reverse_cmd), .shutoff_req(shutoff_req), .position_near(position_near),
      .flux_ready(flux_ready), .decelerating(decelerating), .position_feed(position_feed),
      .out_freq(out_freq), .freq_cmd(freq_cmd), .motor_current(motor_current),
      .dist_to_stop(dist_to_stop), .dist_data(dist_data), .dist_data_adj(dist_data_adj),
      .brake_release_request(brake_release_request), .output_on(output_on),
      .accel_permit(accel_permit), .hold_freq(hold_freq), .irq(irq));
   bsc_brake_model #(.LAG(6)) brake (.pclk(pclk), .presetn(presetn),
      .brake_release_request(brake_release_request), .stuck(stuck),
      .brake_release_done(brake_release_done));

   initial begin
      forever #12.5 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic chk1(input string nm, input logic seen, input logic exp);
      chk(nm, {31'h0, seen}, {31'h0, exp});
   endtask
   // entered right after a rising edge, leaves one idle edge behind
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return output_on;
         1: return brake_release_request;
         2: return accel_permit;
         default: return irq;
      endcase
   endfunction
   task automatic wait_for(input int s, input logic lvl, input string nm);
      cyc = 0;
      while (pick(s) !== lvl && cyc < 2000) begin
         @(posedge pclk);
         cyc++;
      end
      chk1(nm, pick(s), lvl);
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge pclk);
      bad_count++;
      wrap_up();
   end

   initial begin
      repeat (10) @(posedge pclk);
      chk1("reset request", brake_release_request, 1'b0);
      chk("reset hold", {16'h0, hold_freq}, {16'h0, RST_RELEASE_FREQ});
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         if (rows[i].w) apb(rows[i].a, 1'b1, rows[i].d);
         apb(rows[i].a, 1'b0, 32'h0);
         chk("read", rd, rows[i].e);
         chk1("slverr", err, rows[i].a == 8'h24);
      end
      dist_data <= 32'h5;
      apb(ADDR_CTRL, 1'b1, 32'h0);
      chk("adj fwd", dist_data_adj, 32'h5);
      apb(ADDR_CTRL, 1'b1, 32'h1);
      @(posedge pclk);
      chk("adj rev", dist_data_adj, 32'hfffffffb);
      // reverse threshold 9999 falls back to forward 50 percent
      reverse_cmd <= 1'b1;
      motor_current <= 16'h0046;
      start_cmd <= 1'b1;
      wait_for(0, 1'b1, "output on");
      repeat (8) @(posedge pclk);
      chk1("no flux", brake_release_request, 1'b0);
      flux_ready <= 1'b1;
      wait_for(1, 1'b1, "request");
      wait_for(2, 1'b1, "permit");
      chk1("start delay", cyc >= 2 * TK && cyc <= 5 * TK, 1'b1);
      start_cmd <= 1'b0;
      decelerating <= 1'b1;
      out_freq <= 16'h0032;
      wait_for(1, 1'b0, "hold drop");
      chk1("hold time", cyc >= 2 * TK && cyc <= 5 * TK, 1'b1);
      chk1("on in stop", output_on, 1'b1);
      wait_for(0, 1'b0, "off");
      chk1("stop time", cyc >= TK && cyc <= 4 * TK, 1'b1);
      reverse_cmd <= 1'b0;
      decelerating <= 1'b0;
      out_freq <= 16'h0064;
      start_cmd <= 1'b1;
      wait_for(2, 1'b1, "permit 2");
      position_feed <= 1'b1;
      freq_cmd <= 16'h0000;
      repeat (20) @(posedge pclk);
      chk1("no zero drop", brake_release_request, 1'b1);
      // range 9999 hands the drop to the position input
      position_near <= 1'b1;
      wait_for(1, 1'b0, "near drop");
      position_near <= 1'b0;
      wait_for(2, 1'b1, "permit 3");
      apb(ADDR_CTRL, 1'b1, 32'h3);
      wait_for(1, 1'b0, "zero drop");
      chk1("zero drop time", cyc <= 4, 1'b1);
      start_cmd <= 1'b0;
      wait_for(0, 1'b0, "off 2");
      position_feed <= 1'b0;
      freq_cmd <= 16'h0064;
      apb(ADDR_STATUS, 1'b0, 32'h0);
      premagnetize_input <= 1'b1;
      wait_for(1, 1'b1, "premag request");
      shutoff_req <= 1'b1;
      premagnetize_input <= 1'b0;
      repeat (6) @(posedge pclk);
      chk1("shutoff", output_on | brake_release_request, 1'b0);
      shutoff_req <= 1'b0;
      apb(ADDR_STATUS, 1'b0, 32'h0);
      chk1("shutoff event", rd[3], 1'b1);
      // a stuck brake must raise the fault after the fixed timeout
      stuck <= 1'b1;
      start_cmd <= 1'b1;
      wait_for(1, 1'b1, "fault request");
      wait_for(3, 1'b1, "fault irq");
      chk1("fault time", cyc >= 190 * TK, 1'b1);
      // release bit is pending too, so only the engage and shutoff bits stay enabled
      apb(ADDR_MASK, 1'b1, 32'hc);
      chk1("masked", irq, 1'b0);
      apb(ADDR_MASK, 1'b1, 32'h1);
      chk1("unmasked", irq, 1'b1);
      apb(ADDR_STATUS, 1'b0, 32'h0);
      chk1("fault bit", rd[0], 1'b1);
      chk1("cleared", irq, 1'b0);
      apb(ADDR_FREQ, 1'b1, 32'h003c0014);
      chk("hold set", {16'h0, hold_freq}, 32'h14);
      presetn <= 1'b0;
      stuck <= 1'b0;
      start_cmd <= 1'b0;
      @(posedge pclk);
      chk1("mid reset", output_on | brake_release_request, 1'b0);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("reset hold 2", {16'h0, hold_freq}, {16'h0, RST_RELEASE_FREQ});
      wrap_up();
   end
endmodule // bsc_brake_seq_tb
